// [pkg/working_register_set_ops_regs.vh]
// Constants for the accumulator divide and exclusive-OR datapath.
// Assumes inclusion by bare name from the datapath design files.
`ifndef WORKING_REGISTER_SET_OPS_REGS_VH
`define WORKING_REGISTER_SET_OPS_REGS_VH

// ----------------------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------------------
`define OP_FRAC_DIV      3'h0
`define OP_MOD_DIV       3'h1
`define OP_XOR_RR        3'h2
`define OP_XOR_RI        3'h3
`define OP_XNOR_RR       3'h4
`define OP_XNOR_RI       3'h5

// ----------------------------------------------------------------------------
// Widths and register selects
// ----------------------------------------------------------------------------
`define WORD_W           24
`define FRAC_SHIFT       24
`define SEL_X            2'h0
`define SEL_Y            2'h1
`define SEL_Z            2'h2
`define SEL_R            2'h3

// ----------------------------------------------------------------------------
// Instruction lengths in bytes and cycles
// ----------------------------------------------------------------------------
`define FRAC_DIV_BYTES   3'h2
`define FRAC_DIV_CYCLES  6'h14
`define MOD_DIV_BYTES    3'h2
`define MOD_DIV_CYCLES   6'h14
`define LOGIC_RR_BYTES   3'h2
`define LOGIC_RR_CYCLES  6'h03
`define LOGIC_RI_BYTES   3'h5
`define LOGIC_RI_CYCLES  6'h06

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define WORD_RST         24'h000000
`define CNT_RST          6'h00
`define BYTES_RST        3'h0
`define FLAG_RST         1'b0

`endif

// [src/signed_divider.v]
// Combinational signed divider, quotient truncates toward zero.
// Assumes the caller registers the result and never divides by zero usefully.
`timescale 1ns/1ps

module signed_divider #(
  parameter NUM_W = 48,
  parameter DEN_W = 24
) (
  // Operands
  input  wire signed [NUM_W-1:0] num_i,
  input  wire signed [DEN_W-1:0] den_i,
  // Results
  output wire signed [NUM_W-1:0] quot_o,
  output wire signed [NUM_W-1:0] rem_o
);

  wire signed [NUM_W-1:0] den_ext;
  wire signed [NUM_W-1:0] quot_raw;
  wire                    den_zero;

  assign den_ext  = {{(NUM_W-DEN_W){den_i[DEN_W-1]}}, den_i};
  assign den_zero = (den_i == {DEN_W{1'b0}});
  // Division by zero yields all ones and keeps the dividend as remainder.
  // The quotient has its own signed net; sharing a conditional with the
  // unsigned all-ones constant would turn the division unsigned.
  assign quot_raw = num_i / den_ext;
  assign quot_o   = den_zero ? {NUM_W{1'b1}} : quot_raw;
  assign rem_o    = den_zero ? num_i : num_i % den_ext;

endmodule // signed_divider

// [src/working_register_set_divide_xor_ops.v]
// Divide, modulo divide, exclusive-OR and exclusive-NOR for the four working registers.
// Assumes the decoder issues one operation with start_i and waits for done_o.
`timescale 1ns/1ps
`include "working_register_set_ops_regs.vh"

// What this block does
// - Fractional divide shifts the first register left by 24, divides signed by the second, writes the quotient to the first and sets sign and zero.
// - Fractional divide is a two-byte instruction whose result appears after twenty cycles.
// - Modulo divide puts the signed quotient into the first register and the remainder, which wins if both are one, into the second and sets sign and zero.
// - Exclusive-OR combines the first register with a register or 24-bit immediate, writes the first and sets sign and zero.
// - Exclusive-NOR combines the first register with a register or 24-bit immediate, writes the first and sets sign and zero.
// - Register forms of both logic operations take two bytes and three cycles, immediate forms five bytes and six cycles.
module working_register_set_divide_xor_ops (
  // Clock, reset and enable
  input  wire        clk_sys_i,
  input  wire        rst_n_i,
  input  wire        clk_en_i,
  // Instruction issue
  input  wire        start_i,
  input  wire [2:0]  op_i,
  input  wire [1:0]  dst_sel_i,
  input  wire [1:0]  src_sel_i,
  input  wire [23:0] imm_i,
  // Status
  output wire        busy_o,
  output reg         done_o,
  output reg  [2:0]  op_bytes_o,
  output reg         sign_flag_o,
  output reg         zero_flag_o,
  // Working register set
  output reg  [23:0] acc_x_o,
  output reg  [23:0] acc_y_o,
  output reg  [23:0] acc_z_o,
  output reg  [23:0] acc_r_o
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  localparam ST_IDLE = 2'b01;
  localparam ST_RUN  = 2'b10;

  reg  [1:0]  state_reg;
  reg  [5:0]  cnt_reg;
  reg  [5:0]  len_reg;
  reg  [2:0]  op_reg;
  reg  [1:0]  dst_reg;
  reg  [1:0]  src_reg;
  reg  [23:0] a_reg;
  reg  [23:0] b_reg;
  reg  [23:0] working_register_set [0:3];
  reg  [23:0] a_sel;
  reg  [23:0] b_sel;
  reg  [5:0]  len_next;
  reg  [2:0]  bytes_next;
  reg  [23:0] res_next;
  wire        issue;
  wire        last_cycle;
  wire        rem_write;
  wire        sign_next;
  wire        zero_next;
  wire [23:0] rem_word;
  wire [47:0] num;
  wire [47:0] quot;
  wire [47:0] rem;
  integer     i;

  assign busy_o = state_reg[1];

  // --------------------------------------------------------------------------
  // Operand selection
  // --------------------------------------------------------------------------
  always @* begin
    a_sel = working_register_set[dst_sel_i];
    if (op_i == `OP_XOR_RI || op_i == `OP_XNOR_RI) begin
      b_sel = imm_i;
    end else begin
      b_sel = working_register_set[src_sel_i];
    end
  end

  // --------------------------------------------------------------------------
  // Instruction length decode
  // --------------------------------------------------------------------------
  always @* begin
    case (op_i)
      `OP_FRAC_DIV: begin
        len_next   = `FRAC_DIV_CYCLES;
        bytes_next = `FRAC_DIV_BYTES;
      end
      `OP_MOD_DIV: begin
        len_next   = `MOD_DIV_CYCLES;
        bytes_next = `MOD_DIV_BYTES;
      end
      `OP_XOR_RI, `OP_XNOR_RI: begin
        len_next   = `LOGIC_RI_CYCLES;
        bytes_next = `LOGIC_RI_BYTES;
      end
      default: begin
        len_next   = `LOGIC_RR_CYCLES;
        bytes_next = `LOGIC_RR_BYTES;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Arithmetic on captured operands
  // --------------------------------------------------------------------------
  // The fractional form is only meaningful while |a| < |b|/2; beyond that the
  // quotient wraps in 24 bits, and software must keep within range.
  assign num = (op_reg == `OP_FRAC_DIV) ? {a_reg, 24'h000000}
                                        : {{24{a_reg[23]}}, a_reg};

  signed_divider #(
    .NUM_W (48),
    .DEN_W (24)
  ) u_div (
    .num_i  (num),
    .den_i  (b_reg),
    .quot_o (quot),
    .rem_o  (rem)
  );

  always @* begin
    case (op_reg)
      `OP_FRAC_DIV, `OP_MOD_DIV: res_next = quot[23:0];
      `OP_XOR_RR, `OP_XOR_RI:    res_next = a_reg ^ b_reg;
      `OP_XNOR_RR, `OP_XNOR_RI:  res_next = ~(a_reg ^ b_reg);
      default:                   res_next = a_reg;
    endcase
  end

  // --------------------------------------------------------------------------
  // Issue and completion decode
  // --------------------------------------------------------------------------
  // Write-back and status share one strobe, so the decoder never sees the
  // registers and the flags disagree for a cycle.
  assign issue      = (state_reg == ST_IDLE) && start_i;
  assign last_cycle = (state_reg == ST_RUN) && (cnt_reg == len_reg - 6'h01);
  assign rem_write  = (op_reg == `OP_MOD_DIV);
  assign rem_word   = rem[23:0];
  assign sign_next  = res_next[23];
  assign zero_next  = (res_next == 24'h000000);

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= `CNT_RST;
      len_reg   <= `CNT_RST;
      op_reg    <= `OP_FRAC_DIV;
      dst_reg   <= `SEL_X;
      src_reg   <= `SEL_X;
      a_reg     <= `WORD_RST;
      b_reg     <= `WORD_RST;
    end else if (clk_en_i) begin
      case (state_reg)
        ST_IDLE: begin
          if (issue) begin
            // Operands are latched here so writeback cannot disturb them.
            a_reg     <= a_sel;
            b_reg     <= b_sel;
            op_reg    <= op_i;
            dst_reg   <= dst_sel_i;
            src_reg   <= src_sel_i;
            len_reg   <= len_next;
            cnt_reg   <= 6'h01;
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          cnt_reg <= cnt_reg + 6'h01;
          if (last_cycle) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Status outputs
  // --------------------------------------------------------------------------
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_o      <= `FLAG_RST;
      op_bytes_o  <= `BYTES_RST;
      sign_flag_o <= `FLAG_RST;
      zero_flag_o <= `FLAG_RST;
    end else if (clk_en_i) begin
      done_o <= last_cycle;
      if (issue) begin
        op_bytes_o <= bytes_next;
      end
      if (last_cycle) begin
        sign_flag_o <= sign_next;
        zero_flag_o <= zero_next;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Working register write-back
  // --------------------------------------------------------------------------
  // The remainder write comes second, so when both operands name one
  // register that register keeps the remainder.
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (i = 0; i < 4; i = i + 1) begin
        working_register_set[i] <= `WORD_RST;
      end
    end else if (clk_en_i && last_cycle) begin
      working_register_set[dst_reg] <= res_next;
      if (rem_write) begin
        working_register_set[src_reg] <= rem_word;
      end
    end
  end

  always @* begin
    acc_x_o = working_register_set[`SEL_X];
    acc_y_o = working_register_set[`SEL_Y];
    acc_z_o = working_register_set[`SEL_Z];
    acc_r_o = working_register_set[`SEL_R];
  end

endmodule // working_register_set_divide_xor_ops

// [tb/working_register_set_divide_xor_ops_test.sv]
// Self-checking bench for the divide and logic datapath.
// Assumes the datapath and its bound checker are compiled before it.
`timescale 1ns/1ps
module working_register_set_divide_xor_ops_test;
  typedef struct packed {logic [2:0] op; logic [1:0] d, s; logic [23:0] imm, ed, es;} row_t;
  reg         clk_sys_i = 1'b0;
  reg         rst_n_i   = 1'b0;
  reg         clk_en_i  = 1'b1;
  reg         start_i   = 1'b0;
  reg  [2:0]  op_i      = 3'h0;
  reg  [1:0]  dst_sel_i = 2'h0;
  reg  [1:0]  src_sel_i = 2'h0;
  reg  [23:0] imm_i     = 24'h000000;
  wire        busy_o, done_o, sign_flag_o, zero_flag_o;
  wire [2:0]  op_bytes_o;
  wire [23:0] acc_x_o, acc_y_o, acc_z_o, acc_r_o;
  int         bad_count = 0;
  int         total_checks = 0;
  // Registers start at zero, so immediate ops load the operands.
  row_t rows [11] = '{
    '{3'h3, 2'h0, 2'h0, 24'h123456, 24'h123456, 24'h0}, '{3'h5, 2'h1, 2'h0, 24'h0f0f0f, 24'hf0f0f0, 24'h0},
    '{3'h2, 2'h0, 2'h1, 24'h0, 24'he2c4a6, 24'h0}, '{3'h4, 2'h1, 2'h0, 24'h0, 24'hedcba9, 24'h0},
    '{3'h2, 2'h2, 2'h2, 24'h0, 24'h000000, 24'h0}, '{3'h3, 2'h3, 2'h0, 24'h000064, 24'h000064, 24'h0},
    '{3'h3, 2'h2, 2'h0, 24'hfffff9, 24'hfffff9, 24'h0}, '{3'h1, 2'h3, 2'h2, 24'h0, 24'hfffff2, 24'h000002},
    '{3'h3, 2'h0, 2'h0, 24'he2c4a7, 24'h000001, 24'h0}, '{3'h0, 2'h0, 2'h1, 24'h0, 24'hfffff2, 24'h0},
    '{3'h6, 2'h1, 2'h0, 24'h0, 24'hedcba9, 24'h0}};
  working_register_set_divide_xor_ops dut_u (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .clk_en_i    (clk_en_i),
    .start_i     (start_i),
    .op_i        (op_i),
    .dst_sel_i   (dst_sel_i),
    .src_sel_i   (src_sel_i),
    .imm_i       (imm_i),
    .busy_o      (busy_o),
    .done_o      (done_o),
    .op_bytes_o  (op_bytes_o),
    .sign_flag_o (sign_flag_o),
    .zero_flag_o (zero_flag_o),
    .acc_x_o     (acc_x_o),
    .acc_y_o     (acc_y_o),
    .acc_z_o     (acc_z_o),
    .acc_r_o     (acc_r_o)
  );
  initial forever #4 clk_sys_i = ~clk_sys_i;
  function automatic logic [23:0] pick(input logic [1:0] d);
    return d == 2'h0 ? acc_x_o : d == 2'h1 ? acc_y_o : d == 2'h2 ? acc_z_o : acc_r_o;
  endfunction
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (bad_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // One issue; with hold set, start stays up for the first ten busy cycles and must be ignored
  // ---------------------------------------------------------------
  task automatic run(input row_t t, input bit hold);
    int n;
    n = 0;
    {op_i, dst_sel_i, src_sel_i, imm_i, start_i} = {t.op, t.d, t.s, t.imm, 1'b1};
    @(posedge clk_sys_i) #1;
    {start_i, op_i, imm_i} = {hold, 3'h3, 24'hffffff};
    check(busy_o, 1'b1);
    while (done_o !== 1'b1 && n < 40) begin
      @(posedge clk_sys_i) #1;
      n++;
      if (n == 10) start_i = 1'b0;
    end
    check(24'(n), t.op < 3'h2 ? 24'd19 : (t.op == 3'h3 || t.op == 3'h5) ? 24'd5 : 24'd2);
    check(busy_o, 1'b0);
    check(pick(t.d), t.ed);
    check({sign_flag_o, zero_flag_o}, {t.ed[23], t.ed == 24'h0});
    if (t.op == 3'h1) check(pick(t.s), t.es);
    check(op_bytes_o, (t.op == 3'h3 || t.op == 3'h5) ? 3'h5 : 3'h2);
  endtask
  initial begin
    #20000;
    bad_count++;
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    foreach (rows[i]) run(rows[i], 1'b0);
    run('{3'h0, 2'h0, 2'h1, 24'h0, 24'h0000c4, 24'h0}, 1'b1);
    rst_n_i = 1'b0;
    #20;
    check(acc_x_o | acc_y_o | acc_z_o | acc_r_o, 24'h0);
    check({busy_o, done_o, op_bytes_o, sign_flag_o, zero_flag_o}, 24'h0);
    @(posedge clk_sys_i) #1 rst_n_i = 1'b1;
    run(rows[0], 1'b0);
    run('{3'h1, 2'h0, 2'h1, 24'h0, 24'hffffff, 24'h123456}, 1'b0);
    {op_i, dst_sel_i, src_sel_i, start_i} = {3'h2, 2'h0, 2'h1, 1'b1};
    @(posedge clk_sys_i) #1;
    {start_i, clk_en_i} = 2'b00;
    repeat (5) @(posedge clk_sys_i);
    #1 check({busy_o, done_o}, 24'h2);
    clk_en_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1 check(done_o, 1'b1);
    check(acc_x_o, 24'hedcba9);
    wrap_up();
  end
endmodule // working_register_set_divide_xor_ops_test

// [tb/working_register_set_ops_monitor.sv]
// Checker for the divide and logic datapath, bound to its top module.
// Assumes only the top ports; every check is disabled, not paused, while clk_en_i is low.
`timescale 1ns/1ps
module working_register_set_ops_monitor (
  // Clock and reset
  input wire        clk_sys_i,
  input wire        rst_n_i,
  input wire        clk_en_i,
  // Issue and status
  input wire        start_i,
  input wire [2:0]  op_i,
  input wire [1:0]  dst_sel_i,
  input wire        busy_o,
  input wire        done_o,
  input wire [2:0]  op_bytes_o,
  input wire        sign_flag_o,
  input wire        zero_flag_o,
  // Working registers
  input wire [23:0] acc_x_o,
  input wire [23:0] acc_y_o,
  input wire [23:0] acc_z_o,
  input wire [23:0] acc_r_o
);
  // ---------------------------------------------------------------
  // Issue tracking
  // ---------------------------------------------------------------
  // The target is kept from the issue edge, since dst_sel_i may change meanwhile.
  reg  [2:0]  op_reg;
  reg  [1:0]  dst_reg;
  wire        take = start_i && !busy_o && clk_en_i;
  wire [23:0] res  = dst_reg == 2'h0 ? acc_x_o : dst_reg == 2'h1 ? acc_y_o :
                     dst_reg == 2'h2 ? acc_z_o : acc_r_o;
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op_reg  <= 3'h0;
      dst_reg <= 2'h0;
    end else if (take) begin
      op_reg  <= op_i;
      dst_reg <= dst_sel_i;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i || !clk_en_i);
  sequence s_reg_op; !done_o [*2] ##1 done_o; endsequence
  sequence s_imm_op; !done_o [*5] ##1 done_o; endsequence
  sequence s_div_op; busy_o [*8] ##12 $rose(done_o); endsequence
  a_reg_logic_time: assert property (take && (op_i == 3'h2 || op_i == 3'h4) |=> s_reg_op)
    else $error("register logic op timing wrong");
  a_imm_logic_time: assert property (take && (op_i == 3'h3 || op_i == 3'h5) |=> s_imm_op)
    else $error("immediate logic op timing wrong");
  a_divide_time: assert property (take && op_i < 3'h2 |=> s_div_op)
    else $error("divide timing wrong");
  a_done_frees: assert property (done_o |-> !busy_o ##1 !done_o)
    else $error("done not a single free cycle");
  a_write_at_done: assert property (!done_o |-> $stable({acc_x_o, acc_y_o, acc_z_o, acc_r_o}))
    else $error("register written outside done");
  a_flags_from_result: assert property (done_o |-> sign_flag_o == res[23] && zero_flag_o == (res == 24'h0))
    else $error("flags disagree with result");
  a_flags_hold: assert property (!done_o |-> $stable({sign_flag_o, zero_flag_o}))
    else $error("flags moved outside done");
  a_op_length: assert property (done_o |-> op_bytes_o == ((op_reg == 3'h3 || op_reg == 3'h5) ? 3'h5 : 3'h2))
    else $error("byte length wrong");
endmodule // working_register_set_ops_monitor

bind working_register_set_divide_xor_ops working_register_set_ops_monitor mon_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .clk_en_i(clk_en_i),
  .start_i(start_i), .op_i(op_i), .dst_sel_i(dst_sel_i), .busy_o(busy_o), .done_o(done_o),
  .op_bytes_o(op_bytes_o), .sign_flag_o(sign_flag_o), .zero_flag_o(zero_flag_o),
  .acc_x_o(acc_x_o), .acc_y_o(acc_y_o), .acc_z_o(acc_z_o), .acc_r_o(acc_r_o));
